/* File: hdl/eeac_pkg.sv */
package eeac_pkg;
  // Bus geometry
  localparam int ADDR_W = 8;                         // APB byte address width
  localparam int DATA_W = 32;                        // APB data width
  localparam int NV_AW = 9;                          // Array address width, 512 bytes
  localparam int NV_DEPTH = 512;                     // Bytes in the array
  // Register byte offsets
  localparam logic [7:0] OFS_ADDR_LOW = 8'h00;       // nv_addr_low
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;      // nv_addr_high
  localparam logic [7:0] OFS_DATA = 8'h08;           // nv_data_reg
  localparam logic [7:0] OFS_CONTROL = 8'h0c;        // nv_control_reg
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;       // Sticky event flags
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;       // Interrupt enables
  // Control field positions
  localparam int BIT_RD_STROBE = 0;                  // read_strobe
  localparam int BIT_WR_STROBE = 1;                  // write_strobe
  localparam int BIT_WR_ARM = 2;                     // master_write_arm
  // Event field positions, shared by status and mask
  localparam int EV_WR_DONE = 0;                     // Write finished
  localparam int EV_RD_DONE = 1;                     // Read finished
  localparam int EV_WR_ABORT = 2;                    // Write aborted by register change
  localparam int EV_W = 3;                           // Number of events
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;           // Address and data registers
  localparam logic [EV_W-1:0] RST_EV = 3'h0;         // Status and mask
  // Timing
  localparam int CLK_MHZ = 50;                       // System clock rate
  localparam int WRITE_TIME_US = 2500;               // Typical write access time, 2.5 ms
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;  // 125000 cycles
  localparam int WR_CNT_W = 17;                      // Width of the write timer
  localparam logic [2:0] ARM_CYCLES = 3'h4;          // Arm window length
  localparam logic [2:0] WR_STALL_CYCLES = 3'h2;     // Stall after write strobe
  localparam logic [2:0] RD_STALL_CYCLES = 3'h4;     // Stall after read strobe

  // Sequencer states
  typedef enum logic [1:0] {
    EEAC_IDLE = 2'b00,
    EEAC_WRITE = 2'b01,
    EEAC_READ = 2'b10
  } eeac_state_t;

  // Control register image
  typedef struct packed {
    logic arm;                                       // master_write_arm
    logic wr_strobe;                                 // write_strobe
    logic rd_strobe;                                 // read_strobe
  } eeac_ctrl_t;
endpackage

/* File: hdl/eeac_top.sv */
// Operation
// R1: Write starts only while arm bit set
// R2: Arm bit self-clears four clocks after set
// R3: Software waits for write strobe clear
// R4: Arm with strobe zero, strobe within four
// R5: Software keeps interrupts off during sequence
// R6: Write strobe clears when write time elapses
// R7: Write strobe stalls CPU two clocks
// R8: Read strobe loads data, self-clears
// R9: Read strobe stalls CPU four clocks
// R10: Software checks write idle before read
// R11: Address or data write aborts write
// R12: Array holds 512 individually accessed bytes
// R13: Byte address joins high and low registers
`timescale 1ns/10ps
`default_nettype none
module eeac_top
  import eeac_pkg::*;
#(
  parameter int WRITE_CYC = eeac_pkg::WRITE_CYCLES     // Write time in clocks
) (
  input wire logic CLOCK,                                // System clock, 50 MHz
  input wire logic SRST,                                 // Synchronous reset, high
  input wire logic PSEL,                                 // APB select
  input wire logic PENABLE,                              // APB enable
  input wire logic PWRITE,                               // APB direction
  input wire logic [eeac_pkg::ADDR_W-1:0] PADDR,         // APB byte address
  input wire logic [eeac_pkg::DATA_W-1:0] PWDATA,        // APB write data
  output logic [eeac_pkg::DATA_W-1:0] PRDATA,            // APB read data
  output logic PREADY,                                   // APB ready
  output logic PSLVERR,                                  // APB error, unmapped address
  output logic IRQ,                                      // Level interrupt
  output logic CPU_STALL                                 // CPU halt request
);
  import eeac_pkg::*;

  // Array storage
  // Not reset; unwritten bytes read unknown in simulation
  logic [7:0] mem [NV_DEPTH];                            // The byte array

  // Register state and next values
  logic [7:0] addr_lo_ff, nxt_addr_lo;                   // Address low byte
  logic [7:0] addr_hi_ff, nxt_addr_hi;                   // Address high byte
  logic [7:0] data_ff, nxt_data;                         // Data register
  eeac_ctrl_t ctrl_ff, nxt_ctrl;                         // Control bits
  logic [EV_W-1:0] stat_ff, nxt_stat;                    // Sticky events
  logic [EV_W-1:0] mask_ff, nxt_mask;                    // Event enables
  eeac_state_t state_ff, nxt_state;                      // Sequencer state
  logic [2:0] arm_cnt_ff, nxt_arm_cnt;                   // Arm window counter
  logic [2:0] stall_cnt_ff, nxt_stall_cnt;               // CPU stall counter
  logic [WR_CNT_W-1:0] wr_cnt_ff, nxt_wr_cnt;            // Write timer
  logic [NV_AW-1:0] wr_addr_ff, nxt_wr_addr;             // Latched write address
  logic [7:0] wr_data_ff, nxt_wr_data;                   // Latched write data
  // Bus outputs
  logic [DATA_W-1:0] prdata_ff, nxt_prdata;              // Read data
  logic pready_ff, nxt_pready;                           // Ready
  logic pslverr_ff, nxt_pslverr;                         // Error
  logic irq_ff, nxt_irq;                                 // Interrupt
  logic stall_ff, nxt_stall;                             // Stall output
  // Decode helpers
  logic acc_done;                                        // Transfer completes this edge
  logic wr_acc;                                          // Write completes this edge
  logic mem_we;                                          // Commit byte to array
  logic [NV_AW-1:0] nv_addr;                             // Current byte address
  logic [EV_W-1:0] ev_set;                               // Events this cycle
  logic [WR_CNT_W-1:0] wr_load;                          // Write timer start value

  // Unmapped offsets get an error answer
  // Only word offsets decode; a byte-lane address is treated as unmapped
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == OFS_ADDR_LOW) || (a == OFS_ADDR_HIGH) || (a == OFS_DATA) ||
           (a == OFS_CONTROL) || (a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK);
  endfunction

  // Write hit on one register offset
  // Shared by every register write so the decode stays in one place
  function automatic logic hit(input logic w, input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    return w && (a == ofs);
  endfunction

  assign acc_done = PSEL && PENABLE && pready_ff;
  assign wr_acc = acc_done && PWRITE;
  // Only the low bit of the high byte is needed for 512 bytes [R13]
  // The rest of the high byte is kept and read back but never decodes
  assign nv_addr = {addr_hi_ff[0], addr_lo_ff};
  // Timer counts down to zero inclusive, so it loads one less than the length
  assign wr_load = WR_CNT_W'(WRITE_CYC - 1);

  // Register file, sequencer and events
  always_comb begin
    nxt_addr_lo = addr_lo_ff;
    nxt_addr_hi = addr_hi_ff;
    nxt_data = data_ff;
    nxt_ctrl = ctrl_ff;
    nxt_mask = mask_ff;
    nxt_state = state_ff;
    nxt_arm_cnt = arm_cnt_ff;
    nxt_stall_cnt = stall_cnt_ff;
    nxt_wr_cnt = wr_cnt_ff;
    nxt_wr_addr = wr_addr_ff;
    nxt_wr_data = wr_data_ff;
    ev_set = '0;
    mem_we = 1'b0;

    // Arm window runs down and then drops the arm bit [R2]
    // A strobe taken on the last armed edge still counts: it sees the old arm
    if (arm_cnt_ff != 3'h0) begin
      nxt_arm_cnt = arm_cnt_ff - 3'h1;
      if (arm_cnt_ff == 3'h1) begin
        nxt_ctrl.arm = 1'b0;
      end
    end

    // Stall counter runs down by itself
    // Shared by both strobes; they never overlap, as strobes are refused while busy
    if (stall_cnt_ff != 3'h0) begin
      nxt_stall_cnt = stall_cnt_ff - 3'h1;
    end

    // Sequencer
    // One transfer at a time; the array has a single port
    unique case (state_ff)
      EEAC_IDLE: begin
        // Nothing in flight
      end
      EEAC_WRITE: begin
        // Strobe drops when the write time is over [R6]
        // Byte commits on the same edge, so a poll that reads zero finds it stored
        if (wr_cnt_ff == '0) begin
          mem_we = 1'b1;
          nxt_ctrl.wr_strobe = 1'b0;
          nxt_state = EEAC_IDLE;
          ev_set[EV_WR_DONE] = 1'b1;
        end else begin
          nxt_wr_cnt = wr_cnt_ff - WR_CNT_W'(1);
        end
      end
      EEAC_READ: begin
        // Read strobe held for the stall, then cleared by hardware [R8]
        if (stall_cnt_ff == 3'h1) begin
          nxt_ctrl.rd_strobe = 1'b0;
          nxt_state = EEAC_IDLE;
          ev_set[EV_RD_DONE] = 1'b1;
        end
      end
      default: begin
        // Illegal code falls back to idle
        nxt_state = EEAC_IDLE;
      end
    endcase

    // Software writes
    // Registers change only at the taking edge, never during wait states
    if (hit(wr_acc, PADDR, OFS_ADDR_LOW)) begin
      nxt_addr_lo = PWDATA[7:0];
    end
    if (hit(wr_acc, PADDR, OFS_ADDR_HIGH)) begin
      nxt_addr_hi = PWDATA[7:0];
    end
    if (hit(wr_acc, PADDR, OFS_DATA)) begin
      nxt_data = PWDATA[7:0];
    end
    // Touching address or data mid-write kills the write [R11]
    // Limitation: the old byte is kept, but software must treat it as undefined
    if (state_ff == EEAC_WRITE && wr_cnt_ff != '0 &&
        (hit(wr_acc, PADDR, OFS_ADDR_LOW) || hit(wr_acc, PADDR, OFS_ADDR_HIGH) ||
         hit(wr_acc, PADDR, OFS_DATA))) begin
      nxt_ctrl.wr_strobe = 1'b0; // [R11]
      nxt_state = EEAC_IDLE;
      ev_set[EV_WR_ABORT] = 1'b1;
    end
    if (hit(wr_acc, PADDR, OFS_IRQ_MASK)) begin
      nxt_mask = PWDATA[EV_W-1:0];
    end
    if (hit(wr_acc, PADDR, OFS_CONTROL) && state_ff == EEAC_IDLE) begin
      if (PWDATA[BIT_WR_STROBE]) begin
        // Strobe without a live arm is ignored [R1]
        if (ctrl_ff.arm) begin
          nxt_ctrl.wr_strobe = 1'b1; // [R1]
          nxt_state = EEAC_WRITE;
          nxt_wr_cnt = wr_load;
          nxt_wr_addr = nv_addr;
          nxt_wr_data = data_ff;
          nxt_stall_cnt = WR_STALL_CYCLES; // [R7]
        end
      end else if (PWDATA[BIT_WR_ARM]) begin
        // Arm only takes when the strobe is written zero alongside [R4]
        nxt_ctrl.arm = 1'b1;
        nxt_arm_cnt = ARM_CYCLES; // [R2]
      end
      if (PWDATA[BIT_RD_STROBE] && !(PWDATA[BIT_WR_STROBE] && ctrl_ff.arm)) begin
        // Byte lands in the data register at once [R8]
        // The stall only holds the bus; the data is already in place
        nxt_ctrl.rd_strobe = 1'b1;
        nxt_data = mem[nv_addr]; // [R8]
        nxt_state = EEAC_READ;
        nxt_stall_cnt = RD_STALL_CYCLES; // [R9]
      end
    end else if (hit(wr_acc, PADDR, OFS_CONTROL) && PWDATA[BIT_WR_ARM] &&
                 !PWDATA[BIT_WR_STROBE]) begin
      // Arming while busy is still honoured; it times out harmlessly
      // Refusing it instead would need software to retry the arm
      nxt_ctrl.arm = 1'b1;
      nxt_arm_cnt = ARM_CYCLES;
    end

    // Hardware set beats the write-one clear
    // The mask gates only the pin; flags collect whether masked or not
    nxt_stat = stat_ff;
    if (hit(wr_acc, PADDR, OFS_IRQ_STAT)) begin
      nxt_stat = stat_ff & ~PWDATA[EV_W-1:0];
    end
    nxt_stat = nxt_stat | ev_set;
    nxt_irq = |(nxt_stat & nxt_mask);
  end

  // Bus answer: one wait state, longer while the CPU is stalled
  // Read data is zero outside the answer cycle, which keeps the bus quiet
  always_comb begin
    nxt_pready = 1'b0;
    nxt_prdata = '0;
    nxt_pslverr = 1'b0;
    // Stalled accesses wait, which is how the CPU is held [R7] [R9]
    // Gate on the registered count, not the next one: the read strobe drops
    // on the edge the count empties, and an answer built on that same edge
    // would still show the strobe set [R8]
    if (PSEL && PENABLE && !pready_ff && stall_cnt_ff == 3'h0) begin
      nxt_pready = 1'b1;
      nxt_pslverr = !is_mapped(PADDR);
      if (!PWRITE) begin
        unique case (PADDR)
          OFS_ADDR_LOW: nxt_prdata = {24'h000000, addr_lo_ff};
          OFS_ADDR_HIGH: nxt_prdata = {24'h000000, addr_hi_ff};
          OFS_DATA: nxt_prdata = {24'h000000, data_ff};
          OFS_CONTROL: nxt_prdata = {29'h0, ctrl_ff};
          OFS_IRQ_STAT: nxt_prdata = {29'h0, stat_ff};
          OFS_IRQ_MASK: nxt_prdata = {29'h0, mask_ff};
          default: nxt_prdata = '0;
        endcase
      end
    end
    nxt_stall = nxt_stall_cnt != 3'h0;
  end

  // State registers
  // Synchronous reset; the byte array below is left out on purpose
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      addr_lo_ff <= RST_BYTE;
      addr_hi_ff <= RST_BYTE;
      data_ff <= RST_BYTE;
      ctrl_ff <= '0;
      stat_ff <= RST_EV;
      mask_ff <= RST_EV;
      state_ff <= EEAC_IDLE;
      arm_cnt_ff <= 3'h0;
      stall_cnt_ff <= 3'h0;
      wr_cnt_ff <= '0;
      wr_addr_ff <= '0;
      wr_data_ff <= RST_BYTE;
      prdata_ff <= '0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      irq_ff <= 1'b0;
      stall_ff <= 1'b0;
    end else begin
      addr_lo_ff <= nxt_addr_lo;
      addr_hi_ff <= nxt_addr_hi;
      data_ff <= nxt_data;
      ctrl_ff <= nxt_ctrl;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      state_ff <= nxt_state;
      arm_cnt_ff <= nxt_arm_cnt;
      stall_cnt_ff <= nxt_stall_cnt;
      wr_cnt_ff <= nxt_wr_cnt;
      wr_addr_ff <= nxt_wr_addr;
      wr_data_ff <= nxt_wr_data;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      irq_ff <= nxt_irq;
      stall_ff <= nxt_stall;
    end
  end

  // Byte array, one byte committed per finished write [R12]
  // No reset: contents survive, as a nonvolatile array should
  always_ff @(posedge CLOCK) begin
    if (mem_we && !SRST) begin
      mem[wr_addr_ff] <= wr_data_ff; // [R12]
    end
  end

  // Every pin comes straight from a flop, so nothing combinational leaves
  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign IRQ = irq_ff;
  assign CPU_STALL = stall_ff;
endmodule
`default_nettype wire

/* File: tb/eeac_props.sv */
`timescale 1ns/10ps
`default_nettype none
module eeac_props
  import eeac_pkg::*;
(
  input wire logic CLOCK, // Clock
  input wire logic SRST, // Reset
  input wire logic PSEL, // Select
  input wire logic PENABLE, // Enable
  input wire logic PWRITE, // Direction
  input wire logic [7:0] PADDR, // Address
  input wire logic [31:0] PWDATA, // Write data
  input wire logic [31:0] PRDATA, // Read data
  input wire logic PREADY, // Ready
  input wire logic PSLVERR, // Error
  input wire logic IRQ, // Interrupt
  input wire logic CPU_STALL // Stall
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);
  // Control write taken at this edge
  wire logic ctl_wr = PSEL && PENABLE && PREADY && PWRITE && (PADDR == OFS_CONTROL);
  // Stall shapes; an ignored strobe gives none
  sequence stall2_s;
    CPU_STALL [*2] ##1 !CPU_STALL;
  endsequence
  sequence stall4_s;
    CPU_STALL [*4] ##1 !CPU_STALL;
  endsequence
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  ready_req_a: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready without access");
  ready_wait_a: assert property (PSEL && !PENABLE && !CPU_STALL |=> !PREADY ##1 PREADY)
    else $error("wait state count wrong");
  ready_bound_a: assert property (PSEL && PENABLE |-> ##[0:5] PREADY)
    else $error("access never answered");
  rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside answer");
  map_err_a: assert property (PREADY && PADDR[1:0] == 2'b00 |-> PSLVERR == (PADDR > OFS_IRQ_MASK))
    else $error("error flag wrong");
  stall_blocks_a: assert property (CPU_STALL |-> !PREADY)
    else $error("answer during stall");
  wr_stall_a: assert property (ctl_wr && PWDATA[1:0] == 2'b10 |=> stall2_s or !CPU_STALL)
    else $error("write stall length wrong");
  rd_stall_a: assert property (ctl_wr && PWDATA[1:0] == 2'b01 |=> stall4_s or !CPU_STALL)
    else $error("read stall length wrong");
  stall_exit_a: assert property (CPU_STALL ##1 !CPU_STALL |-> !PREADY)
    else $error("answer built before stall ended");
endmodule
bind eeac_top eeac_props eeac_props_inst (.CLOCK(CLOCK), .SRST(SRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ), .CPU_STALL(CPU_STALL));
`default_nettype wire

/* File: tb/eeac_nv_model.sv */
`timescale 1ns/10ps
`default_nettype none
module eeac_nv_model
  import eeac_pkg::*;
;
  // Expected array image, one byte per location
  logic [7:0] mem [NV_DEPTH];
  // Location from the two address bytes; upper high bits unused
  function automatic void put(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] d);
    mem[{hi[0], lo}] = d;
  endfunction
  function automatic logic [7:0] get(input logic [7:0] hi, input logic [7:0] lo);
    return mem[{hi[0], lo}];
  endfunction
endmodule
`default_nettype wire

/* File: tb/eeac_top_test.sv */
`timescale 1ns/10ps
`default_nettype none
module eeac_top_test;
  import eeac_pkg::*;
  localparam int WC = 20; // Short write time for simulation
  logic CLOCK = 1'b0, SRST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, q;
  logic PREADY, PSLVERR, IRQ, CPU_STALL, err;
  int bad_count = 0, checks = 0, cyc = 0, stall_n = 0;
  logic [7:0] ah [3] = '{8'h01, 8'h00, 8'h01}; // Mid-range, first and last addresses
  logic [7:0] al [3] = '{8'h34, 8'h00, 8'hff};
  logic [7:0] dv [3] = '{8'ha5, 8'h5a, 8'h3c};
  always #10 CLOCK = ~CLOCK;
  eeac_top #(.WRITE_CYC(WC)) eeac_top_inst (.CLOCK(CLOCK), .SRST(SRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ), .CPU_STALL(CPU_STALL));
  eeac_nv_model eeac_nv_model_inst ();
  // Tally of stalled cycles
  always @(posedge CLOCK) if (CPU_STALL === 1'b1) stall_n <= stall_n + 1;
  // Hang guard, far above the expected run
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One APB transfer; ready sampled at the edge before it updates
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    q = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0; PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(q, exp, "register read");
  endtask
  // Full byte write: address, data, arm, strobe, poll
  task automatic nvw(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] d);
    int t0;
    wr(OFS_ADDR_LOW, {24'h0, lo});
    wr(OFS_ADDR_HIGH, {24'h0, hi});
    wr(OFS_DATA, {24'h0, d});
    wr(OFS_CONTROL, 32'h4);
    wr(OFS_CONTROL, 32'h2);
    t0 = cyc;
    chk(OFS_CONTROL, 32'h2);
    for (int i = 0; i < 40 && q[1] !== 1'b0; i++) apb(1'b0, OFS_CONTROL, 32'h0);
    cmp(q, 32'h0, "write end");
    cmp({31'h0, (cyc - t0) >= WC}, 32'h1, "write too fast");
    eeac_nv_model_inst.put(hi, lo, d);
  endtask
  initial begin
    repeat (12) @(posedge CLOCK);
    SRST <= 1'b0;
    for (int a = 0; a < 6; a++) chk(8'(a * 4), 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    cmp({31'h0, err}, 32'h1, "unmapped error");
    wr(OFS_IRQ_MASK, 32'h7);
    chk(OFS_IRQ_MASK, 32'h7);
    wr(OFS_CONTROL, 32'h2);
    chk(OFS_CONTROL, 32'h0);
    stall_n = 0;
    nvw(ah[0], al[0], dv[0]);
    cmp(stall_n, 2, "write stall");
    cmp({31'h0, IRQ}, 32'h1, "done interrupt");
    chk(OFS_IRQ_STAT, 32'h1);
    wr(OFS_IRQ_STAT, 32'h1);
    chk(OFS_IRQ_STAT, 32'h0);
    cmp({31'h0, IRQ}, 32'h0, "interrupt cleared");
    // Arm window: seen set, then gone, late strobe ignored
    wr(OFS_CONTROL, 32'h4);
    chk(OFS_CONTROL, 32'h4);
    chk(OFS_CONTROL, 32'h0);
    wr(OFS_CONTROL, 32'h4);
    repeat (3) @(posedge CLOCK);
    wr(OFS_CONTROL, 32'h2);
    chk(OFS_CONTROL, 32'h0);
    for (int i = 1; i < 3; i++) nvw(ah[i], al[i], dv[i]);
    wr(OFS_IRQ_STAT, 32'h7);
    wr(OFS_IRQ_MASK, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_ADDR_LOW, {24'h0, al[i]});
      wr(OFS_ADDR_HIGH, {24'h0, ah[i]});
      stall_n = 0;
      wr(OFS_CONTROL, 32'h1);
      chk(OFS_CONTROL, 32'h0);
      cmp(stall_n, 4, "read stall");
      chk(OFS_DATA, {24'h0, eeac_nv_model_inst.get(ah[i], al[i])});
    end
    chk(OFS_IRQ_STAT, 32'h2);
    cmp({31'h0, IRQ}, 32'h0, "masked interrupt");
    wr(OFS_IRQ_MASK, 32'h7);
    chk(OFS_IRQ_STAT, 32'h2);
    cmp({31'h0, IRQ}, 32'h1, "unmasked interrupt");
    wr(OFS_IRQ_STAT, 32'h7);
    // Data register written mid-write aborts it
    wr(OFS_CONTROL, 32'h4);
    wr(OFS_CONTROL, 32'h2);
    wr(OFS_DATA, 32'h11);
    chk(OFS_CONTROL, 32'h0);
    chk(OFS_IRQ_STAT, 32'h4);
    complete_run();
  end
endmodule
`default_nettype wire
